// *** dv/sph_dev_model.sv ***
// Eight-flag token space: left port on host pins, right port from the bench.
// Assumes host pins change only after clk_in edges.
`timescale 1ns/1ps
`default_nettype none
module sph_dev_model (
  input wire logic clk_in,
  input wire logic sel_n_in,
  input wire logic cs_n_in,
  input wire logic wr_n_in,
  input wire logic re_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic r_wr_in,
  input wire logic [2:0] r_idx_in,
  input wire logic r_bit_in,
  output logic [15:0] data_out
);
  logic [7:0] req_l = 8'h00; // Not cleared at power-up, so init matters
  logic [7:0] req_r = 8'hff;
  logic [7:0] own_l = 8'h00;
  logic [7:0] own_r = 8'h00;
  logic rd_q = 1'b1;
  wire rd_act = !sel_n_in && !re_n_in;
  // Request latches, apart from any memory array
  always @(posedge clk_in) begin
    if (!sel_n_in && cs_n_in && !wr_n_in) req_l[addr_in[2:0]] <= data_in[0];
    if (r_wr_in) req_r[r_idx_in] <= r_bit_in;
  end
  // Grant: a free flag goes to the first request; left wins a same-edge tie
  always @(posedge clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (!own_l[i] && !own_r[i]) begin
        own_l[i] <= !req_l[i];
        own_r[i] <= req_l[i] && !req_r[i];
      end else if (own_l[i] && req_l[i]) begin
        own_l[i] <= 1'b0;
        own_r[i] <= !req_r[i];
      end else if (own_r[i] && req_r[i]) begin
        own_r[i] <= 1'b0;
        own_l[i] <= !req_l[i];
      end
    end
  end
  // Captured as the strobe opens so a remote write cannot tear a read
  always @(posedge rd_act) rd_q = !own_l[addr_in[2:0]];
  // Released bus shows the inverse of the live flag, so an early sample fails
  assign data_out = rd_act ? {16{rd_q}} : {16{own_l[addr_in[2:0]]}};
endmodule
`default_nettype wire

// *** dv/sph_host_bench.sv ***
// Self-checking bench: host on the left port of the model, right port driven here.
// Assumes a 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sph_host_bench;
  import sph_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [SPH_IDX_W-1:0] cmd_idx_in = 3'h0;
  logic cmd_bit_in = 1'b0;
  logic r_wr = 1'b0;
  logic [2:0] r_idx = 3'h0;
  logic r_bit = 1'b1;
  logic [SPH_DATA_W-1:0] data_in;
  logic cmd_ready_out, done_out, granted_out, rd_flag_out, sel_n, cs_n, wr_n, re_n, oe_n;
  logic [SPH_ADDR_W-1:0] addr_out;
  logic [SPH_DATA_W-1:0] data_out;
  int miscompares = 0;
  int checks = 0;
  sph_host #(.PHASE_CYC(4)) i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_idx_in(cmd_idx_in),
    .cmd_bit_in(cmd_bit_in), .data_in(data_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .granted_out(granted_out), .rd_flag_out(rd_flag_out),
    .token_space_select_n_out(sel_n), .chip_select_n_out(cs_n), .write_n_out(wr_n),
    .read_enable_n_out(re_n), .addr_out(addr_out), .data_out(data_out), .data_oe_n_out(oe_n));
  sph_dev_model i_dev (.clk_in(mclk_in), .sel_n_in(sel_n), .cs_n_in(cs_n), .wr_n_in(wr_n),
    .re_n_in(re_n), .addr_in(addr_out), .data_in(data_out), .r_wr_in(r_wr),
    .r_idx_in(r_idx), .r_bit_in(r_bit), .data_out(data_in));
  initial forever #2.5 mclk_in = ~mclk_in;
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("FAIL t=%0t waited %h limit %h", $time, n, lim);
      test_done();
    end
  endtask
  // One host command, waiting for ready and then done under a bound
  task automatic run(input logic [1:0] op, input logic [2:0] idx, input logic b);
    int n;
    for (n = 0; n < 20 && cmd_ready_out !== 1'b1; n++) @(negedge mclk_in);
    limit(n, 20);
    cmd_op_in = op;
    cmd_idx_in = idx;
    cmd_bit_in = b;
    cmd_valid_in = 1'b1;
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
    for (n = 0; n < 400 && done_out !== 1'b1; n++) @(negedge mclk_in);
    limit(n, 400);
  endtask
  task automatic right_wr(input logic [2:0] idx, input logic b);
    r_idx = idx;
    r_bit = b;
    r_wr = 1'b1;
    @(negedge mclk_in);
    r_wr = 1'b0;
  endtask
  task automatic t_init();
    run(SPH_OP_INIT, 3'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run(SPH_OP_READ, i[2:0], 1'b0);
      check(1'b1, rd_flag_out);
    end
  endtask
  task automatic t_own();
    run(SPH_OP_ACQUIRE, 3'h3, 1'b0);
    check(1'b1, granted_out);
    run(SPH_OP_ACQUIRE, 3'h3, 1'b0);
    check(1'b1, granted_out);
    run(SPH_OP_WRITE, 3'h3, 1'b1);
    run(SPH_OP_READ, 3'h3, 1'b0);
    check(1'b1, rd_flag_out);
  endtask
  // Right owns flag 5; left request waits, then takes over on release
  task automatic t_contend();
    right_wr(3'h5, 1'b0);
    run(SPH_OP_ACQUIRE, 3'h5, 1'b0);
    check(1'b0, granted_out);
    run(SPH_OP_READ, 3'h5, 1'b0);
    check(1'b1, rd_flag_out);
    right_wr(3'h5, 1'b1);
    run(SPH_OP_READ, 3'h5, 1'b0);
    check(1'b0, rd_flag_out);
    run(SPH_OP_WRITE, 3'h5, 1'b1);
    run(SPH_OP_READ, 3'h5, 1'b0);
    check(1'b1, rd_flag_out);
  endtask
  task automatic t_withdraw();
    right_wr(3'h6, 1'b0);
    run(SPH_OP_ACQUIRE, 3'h6, 1'b0);
    check(1'b0, granted_out);
    run(SPH_OP_WRITE, 3'h6, 1'b1);
    right_wr(3'h6, 1'b1);
    run(SPH_OP_READ, 3'h6, 1'b0);
    check(1'b1, rd_flag_out);
  endtask
  initial begin
    repeat (10) @(negedge mclk_in);
    reset_in = 1'b0;
    t_init();
    t_own();
    t_contend();
    t_withdraw();
    test_done();
  end
endmodule
bind sph_host sph_host_sva #(.PHASE_CYC(PHASE_CYC)) i_sva (.mclk_in(mclk_in),
  .reset_in(reset_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
  .token_space_select_n_out(token_space_select_n_out), .chip_select_n_out(chip_select_n_out),
  .write_n_out(write_n_out), .read_enable_n_out(read_enable_n_out), .addr_out(addr_out),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out));
`default_nettype wire

// *** dv/sph_host_sva.sv ***
// Pin-level checks for the token-space host sequencer.
// Assumes binding into sph_host; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sph_host_sva
  import sph_pkg::*;
#(
  parameter int PHASE_CYC = 4
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic token_space_select_n_out,
  input wire logic chip_select_n_out,
  input wire logic write_n_out,
  input wire logic read_enable_n_out,
  input wire logic [SPH_ADDR_W-1:0] addr_out,
  input wire logic [SPH_DATA_W-1:0] data_out,
  input wire logic data_oe_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic [SPH_CNT_W-1:0] rd_cnt;
  // Read strobe length; a short strobe could miss the latched flag
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) rd_cnt <= '0;
    else if (read_enable_n_out) rd_cnt <= '0;
    else if (rd_cnt != '1) rd_cnt <= rd_cnt + 1'b1;
  end
  sequence s_wr_end;
    $rose(write_n_out);
  endsequence
  sequence s_rd_end;
    $rose(read_enable_n_out);
  endsequence
  a_cs_held_high: assert property (chip_select_n_out) else $error("memory select active");
  a_addr_upper_zero: assert property (addr_out[15:3] == 13'h0000) else $error("upper addr");
  a_write_in_space: assert property (
    !write_n_out |-> !token_space_select_n_out && !data_oe_n_out)
    else $error("write outside token space");
  a_read_no_drive: assert property (
    !read_enable_n_out |-> data_oe_n_out && write_n_out && !token_space_select_n_out)
    else $error("bad read pins");
  a_read_length: assert property (s_rd_end |-> rd_cnt >= PHASE_CYC) else $error("short read");
  a_gap_after_wr: assert property (s_wr_end |-> token_space_select_n_out)
    else $error("no select gap");
  a_done_pulse: assert property (done_out |-> cmd_ready_out ##1 !done_out) else $error("done");
  a_wr_data_bit: assert property (!data_oe_n_out |-> data_out[15:1] == 15'h0000)
    else $error("write data beyond bit zero");
  a_idle_quiet: assert property (cmd_ready_out |-> token_space_select_n_out && data_oe_n_out)
    else $error("pins busy while idle");
endmodule
`default_nettype wire

// *** inc/sph_pins_if.sv ***
// Pin group of one memory port, passed from the sequencer to the pin driver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sph_pins_if;
  logic sel;
  logic wr;
  logic rd;
  logic [sph_pkg::SPH_IDX_W-1:0] idx;
  logic dbit;
  modport seq (output sel, output wr, output rd, output idx, output dbit);
  modport drv (input sel, input wr, input rd, input idx, input dbit);
endinterface
`default_nettype wire

// *** inc/sph_pkg.sv ***
// Constants and types for the token-space host controller.
// Assumes one 200 MHz clock and a dual-port memory with a token space outside.
// Operation
// R1: Device holds eight flags apart from memory.
// R2: Write zero requests, write one releases.
// R3: Token select low, then ordinary memory access.
// R4: Three low address bits pick the flag.
// R5: Writes use data bit zero only.
// R6: Zero on free flag: writer zero, other one.
// R7: Only the owner may change the flag.
// R8: Owner writing one frees the flag.
// R9: Non-owner zero waits in its request latch.
// R10: First request latch presenting zero wins.
// R11: Pending request takes over at release.
// R12: New owner stays low until it writes one.
// R13: Read spreads flag over every data bit.
// R14: Read value latched while select and enable active.
// R15: Host drops select between polling reads.
// R16: Host writes zero first, then reads back.
// R17: After failure, poll or withdraw with one.
// R18: Simultaneous requests grant exactly one port.
// R19: Earlier request wins the flag.
// R20: Same-instant tie goes to one port.
// R21: Host writes one to every flag at start.
// R22: Host keeps memory chip select high.
// R23: Same-evaluation requests use fixed tie-break.
// R24: Redundant writes leave ownership unchanged.
package sph_pkg;
  localparam int SPH_DATA_W = 16;
  localparam int SPH_ADDR_W = 16;
  localparam int SPH_IDX_W = 3;
  localparam int SPH_NUM_FLAGS = 8;
  localparam int SPH_CLK_MHZ = 200;
  // Bus phase time in ns and derived cycle count
  localparam int SPH_SETUP_NS = 20;
  localparam int SPH_SETUP_CYC = (SPH_SETUP_NS * SPH_CLK_MHZ + 999) / 1000;
  localparam int SPH_CNT_W = 8;
  localparam logic [1:0] SPH_OP_WRITE = 2'h0;
  localparam logic [1:0] SPH_OP_READ = 2'h1;
  localparam logic [1:0] SPH_OP_ACQUIRE = 2'h2;
  localparam logic [1:0] SPH_OP_INIT = 2'h3;
  typedef enum logic [5:0] {
    SPH_IDLE = 6'h01,
    SPH_WR = 6'h02,
    SPH_GAP = 6'h04,
    SPH_RD = 6'h08,
    SPH_DONE = 6'h10,
    SPH_NEXT = 6'h20
  } sph_state_t;
endpackage

// *** verilog/sph_host.sv ***
// Host sequencer for the token space of a dual-port memory.
// Assumes the memory answers reads within SPH_SETUP_NS; one host per port.
`timescale 1ns/1ps
`default_nettype none
module sph_host
  import sph_pkg::*;
#(
  parameter int PHASE_CYC = sph_pkg::SPH_SETUP_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [SPH_IDX_W-1:0] cmd_idx_in,
  input wire logic cmd_bit_in,
  input wire logic [SPH_DATA_W-1:0] data_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic granted_out,
  output logic rd_flag_out,
  output logic token_space_select_n_out,
  output logic chip_select_n_out,
  output logic write_n_out,
  output logic read_enable_n_out,
  output logic [SPH_ADDR_W-1:0] addr_out,
  output logic [SPH_DATA_W-1:0] data_out,
  output logic data_oe_n_out
);
  sph_pins_if pins();
  sph_state_t state;
  sph_state_t next_state;
  logic [1:0] op;
  logic [SPH_IDX_W-1:0] idx;
  logic dbit;
  logic [SPH_CNT_W-1:0] cnt;
  logic [SPH_DATA_W-1:0] s1, s2, s3;
  logic rd_val;

  // Op decode shared by the captured and the incoming command
  function automatic logic sph_is_init(input logic [1:0] o);
    return (o == SPH_OP_INIT);
  endfunction
  function automatic logic sph_is_acquire(input logic [1:0] o);
    return (o == SPH_OP_ACQUIRE);
  endfunction

  wire phase_end = (cnt == SPH_CNT_W'(PHASE_CYC - 1));
  // A read may outlast its count while the data pins settle
  wire phase_over = (cnt >= SPH_CNT_W'(PHASE_CYC - 1));
  // A read that never settles gives up instead of hanging the port
  wire rd_timeout = (cnt == {SPH_CNT_W{1'b1}});
  // Per bit: later stages agree, and every bit shows the same flag
  wire [SPH_DATA_W-1:0] bit_agree;
  wire [SPH_DATA_W-1:0] bit_same;
  genvar g;
  generate
    for (g = 0; g < SPH_DATA_W; g = g + 1) begin : g_bits
      assign bit_agree[g] = (s2[g] == s3[g]);
      assign bit_same[g] = (s3[g] == s3[0]); // R13
    end
  endgenerate
  // Agreeing second and third stages mean a settled bus
  wire data_stable = &bit_agree;
  wire rd_zero = (s3 == '0); // R13
  wire rd_settled = phase_over && data_stable && (&bit_same);
  wire rd_finish = rd_settled || rd_timeout;
  wire last_flag = (idx == SPH_IDX_W'(SPH_NUM_FLAGS - 1));
  wire has_read = (op == SPH_OP_READ) || (op == SPH_OP_ACQUIRE);
  wire has_write = (op != SPH_OP_READ);

  // Sequence per command:
  // write: select and strobe for one phase, then a select-free gap
  // read: strobe held until the sampled pins agree
  // acquire: write zero, gap, then read back, never the other way round
  // init: write one to every flag in turn from flag zero
  // Trade-off: a fixed phase count is simple but slow for fast parts
  always_comb begin
    next_state = state;
    case (state)
      SPH_IDLE: begin
        if (cmd_valid_in) begin
          next_state = (cmd_op_in == SPH_OP_READ) ? SPH_RD : SPH_WR; // R16
        end
      end
      SPH_WR: begin
        if (phase_end) begin
          next_state = SPH_GAP;
        end
      end
      SPH_GAP: begin
        // Gap drops select so the next read latches afresh
        if (phase_end) begin
          if (sph_is_init(op)) begin
            next_state = SPH_NEXT; // R21
          end else if (has_read) begin
            next_state = SPH_RD; // R15
          end else begin
            next_state = SPH_DONE;
          end
        end
      end
      SPH_RD: begin
        if (rd_finish) begin
          next_state = SPH_DONE;
        end
      end
      SPH_NEXT: begin
        next_state = last_flag ? SPH_DONE : SPH_WR;
      end
      SPH_DONE: next_state = SPH_IDLE;
      default: next_state = SPH_IDLE;
    endcase
  end

  // Pin levels for the driver
  assign pins.sel = (state == SPH_WR) || (state == SPH_RD); // R3
  assign pins.wr = (state == SPH_WR) && has_write;
  assign pins.rd = (state == SPH_RD);
  assign pins.idx = idx;
  assign pins.dbit = sph_is_init(op) ? 1'b1 : dbit; // R2

  sph_pin_drv u_drv (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pins(pins),
    .token_space_select_n_out(token_space_select_n_out),
    .chip_select_n_out(chip_select_n_out),
    .write_n_out(write_n_out),
    .read_enable_n_out(read_enable_n_out),
    .addr_out(addr_out),
    .data_out(data_out),
    .data_oe_n_out(data_oe_n_out)
  );

  // Three-stage sampling of the data pins
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= data_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Command capture; init always starts at flag zero
  wire accept = (state == SPH_IDLE) && cmd_valid_in;
  wire step_flag = (state == SPH_NEXT) && !last_flag;
  wire [SPH_IDX_W-1:0] cmd_idx = sph_is_init(cmd_op_in) ? '0 : cmd_idx_in; // R4
  wire [SPH_IDX_W-1:0] next_idx = accept ? cmd_idx : (step_flag ? idx + 1'b1 : idx); // R21
  wire [1:0] next_op = accept ? cmd_op_in : op;
  // An acquire always requests with a zero
  wire next_dbit = accept ? (sph_is_acquire(cmd_op_in) ? 1'b0 : cmd_bit_in) : dbit;
  wire [SPH_CNT_W-1:0] next_cnt = (next_state != state) ? '0 : cnt + 1'b1;

  // State and phase counter
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= SPH_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Command fields hold still for the whole command, except idx stepping through the flags of an init
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      op <= SPH_OP_READ;
      idx <= '0;
      dbit <= 1'b1;
    end else begin
      op <= next_op;
      idx <= next_idx;
      dbit <= next_dbit;
    end
  end

  // Read result; a read that never settles counts as not ours, the safe answer
  wire rd_capture = (state == SPH_RD) && rd_finish;
  wire next_rd_val = rd_capture ? (rd_settled ? ~rd_zero : 1'b1) : rd_val;
  wire at_done = (state == SPH_DONE);
  wire next_rd_flag = at_done ? (has_read ? rd_val : 1'b1) : rd_flag_out;
  // A failed acquire stays pending; the user polls or writes one to withdraw
  wire next_granted = at_done ? (sph_is_acquire(op) && !rd_val) : granted_out; // R17

  // Ready is high exactly while the sequencer idles
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_ready_out <= 1'b0;
    end else begin
      cmd_ready_out <= (next_state == SPH_IDLE);
    end
  end

  // Done pulses for the one cycle after the SPH_DONE state
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= at_done;
    end
  end

  // Latched read value, taken as the read phase ends
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_val <= 1'b1;
    end else begin
      rd_val <= next_rd_val;
    end
  end

  // Results stand until the next command finishes
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_flag_out <= 1'b1;
      granted_out <= 1'b0;
    end else begin
      rd_flag_out <= next_rd_flag;
      granted_out <= next_granted;
    end
  end
endmodule
`default_nettype wire

// *** verilog/sph_pin_drv.sv ***
// Registered pin driver: turns sequencer levels into active-low pin outputs.
// Assumes the sequencer changes levels at most once per cycle.
`timescale 1ns/1ps
`default_nettype none
module sph_pin_drv
  import sph_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  sph_pins_if.drv pins,
  output logic token_space_select_n_out,
  output logic chip_select_n_out,
  output logic write_n_out,
  output logic read_enable_n_out,
  output logic [SPH_ADDR_W-1:0] addr_out,
  output logic [SPH_DATA_W-1:0] data_out,
  output logic data_oe_n_out
);
  wire [SPH_ADDR_W-1:0] next_addr;
  // Higher address bits are don't care; driven zero for a quiet bus
  assign next_addr = {{(SPH_ADDR_W-SPH_IDX_W){1'b0}}, pins.idx}; // R4
  // Every pin straight from a flop; bus idle at reset
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      token_space_select_n_out <= 1'b1;
      chip_select_n_out <= 1'b1;
      write_n_out <= 1'b1;
      read_enable_n_out <= 1'b1;
      addr_out <= '0;
      data_out <= '0;
      data_oe_n_out <= 1'b1;
    end else begin
      token_space_select_n_out <= ~pins.sel; // R3
      chip_select_n_out <= 1'b1; // R22
      write_n_out <= ~pins.wr;
      read_enable_n_out <= ~pins.rd;
      addr_out <= next_addr;
      data_out <= {{(SPH_DATA_W-1){1'b0}}, pins.dbit}; // R5
      data_oe_n_out <= ~pins.wr; // Low while we drive
    end
  end
endmodule
`default_nettype wire
